// [logic/ssps_pkg.sv]
// Purpose: Shared constants and code conversions for the SSI position link
// Assumes: 20 MHz system clock on both ends
// Notes: Frame is 25 bits, position in the low 20 bits
`default_nettype none
package ssps_pkg;

    localparam int FRAME_BITS = 25;
    localparam int POS_BITS = 20;
    localparam int PAD_BITS = FRAME_BITS - POS_BITS;
    localparam logic [PAD_BITS-1:0] PAD_ZERO = 5'h00;
    localparam logic [POS_BITS-1:0] POS_MAX = 20'hfffff;
    localparam int RESOLUTION_NM = 5000;
    localparam int IDX_W = 5;

    localparam int MCLK_HZ = 20000000;
    localparam int MCLK_PERIOD_NS = 50;
    localparam int MONO_TIME_NS = 12000;
    localparam int MONO_CYC = (MONO_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int MONO_W = $clog2(MONO_CYC + 1);
    localparam int PAUSE_TIME_NS = 16000;
    localparam int PAUSE_CYC = PAUSE_TIME_NS / MCLK_PERIOD_NS + 1;
    localparam int CNT_W = $clog2(PAUSE_CYC + 1);

    localparam int SCLK_MIN_HZ = 100000;
    localparam int SCLK_MAX_HZ = 1000000;
    localparam int HALF_DIV_MIN = MCLK_HZ / (2 * SCLK_MAX_HZ);
    localparam int HALF_DIV_MAX = MCLK_HZ / (2 * SCLK_MIN_HZ);

    localparam int FIFO_DEPTH = 8;
    localparam bit GRAY_DEFAULT = 1'b1;

    function automatic logic [POS_BITS-1:0] to_gray(input logic [POS_BITS-1:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    function automatic logic [POS_BITS-1:0] from_gray(input logic [POS_BITS-1:0] g);
        logic [POS_BITS-1:0] b;
        b = g;
        for (int i = POS_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : from_gray

endpackage : ssps_pkg
`default_nettype wire

// [logic/ssps_if.sv]
// Purpose: Serial clock and data pair between master and position slave
// Assumes: Differential pairs modelled as single-ended levels
// Notes: No clocking block; master drives sclk, slave drives sdata
`timescale 1ns/100ps
`default_nettype none
interface ssps_if;
    logic sclk;
    logic sdata;
    modport device (input sclk, output sdata);
    modport host (output sclk, input sdata);
endinterface : ssps_if
`default_nettype wire

// [logic/ssps_slave.sv]
// Purpose: SSI position slave end, plus the shared stream FIFO
// Assumes: Master keeps sclk high between frames and pauses over 16 us
// Notes: Shift logic runs on the link clock; monoflop timing on mclk_i
//
// Overview of operation
// [RULE_01] Master alone clocks frames, slave never initiates
// [RULE_02] First falling edge freezes position for frame
// [RULE_03] Each rising edge presents next bit, MSB first
// [RULE_04] Master supplies word length plus one edges
// [RULE_05] Surplus clocks shift out logic low
// [RULE_06] After 12 us monoflop, data high, ready
// [RULE_07] Gray or binary fixed per variant
// [RULE_08] Frame is 25 bits, right aligned
// [RULE_09] Position in low 20 bits, top five zero
// [RULE_10] LSB sent on last frame clock
// [RULE_11] One count equals 0.005 mm travel
// [RULE_12] Position never exceeds 1,048,575
// [RULE_13] Master clock between 100 kHz and 1 MHz
// [RULE_14] Master slows clock for longer cables
// [RULE_15] Master pauses over 16 us between frames
// [RULE_16] Position rises monotonically in standard direction
// [RULE_17] No zero setting or preset function
// [RULE_18] Master holds clock high between frames
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Stream FIFO
// ****************************************
module ssps_fifo #(
    parameter int WIDTH = ssps_pkg::POS_BITS,
    parameter int DEPTH = ssps_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // Pointers carry one wrap bit; DEPTH must be a power of two
    assign empty = (wr_r == rd_r);
    assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_r[rd_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_r <= '0;
        end else if (push) begin
            wr_r <= wr_r + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_r <= '0;
        end else if (pop) begin
            rd_r <= rd_r + (AW+1)'(1);
        end
    end
endmodule : ssps_fifo

// ****************************************
// Position slave
// ****************************************
module ssps_slave #(
    parameter bit GRAY_CODE = ssps_pkg::GRAY_DEFAULT,
    parameter int DEPTH = ssps_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [ssps_pkg::POS_BITS-1:0] pos_i,
    input wire logic pos_valid_i,
    output logic pos_ready_o,
    output logic busy_o,
    ssps_if.device link
);
    localparam int PB = ssps_pkg::POS_BITS;
    localparam int FB = ssps_pkg::FRAME_BITS;
    localparam int IW = ssps_pkg::IDX_W;
    localparam int MW = ssps_pkg::MONO_W;

    logic fifo_valid;
    logic [PB-1:0] fifo_data;
    logic pop;
    logic [PB-1:0] stable_r;
    logic [1:0] sclk_sync_r;
    logic [1:0] busy_sync_r;
    logic sclk_s;
    logic busy_s;
    logic sclk_d_r;
    logic [MW-1:0] mono_r;
    logic clr_r;
    logic frm_rst_n;
    logic frame_r;
    logic [FB-1:0] snap_r;
    logic [IW-1:0] idx_r;
    logic out_r;

    // ****************************************
    // Position intake (mclk domain)
    // ****************************************
    ssps_fifo #(
        .WIDTH(PB),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_valid_i(pos_valid_i),
        .in_ready_o(pos_ready_o),
        .in_data_i(pos_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_data)
    );

    // Stalls while a frame runs, so the FIFO can fill
    assign pop = fifo_valid && !busy_s && sclk_s;

    // Offered word is binary, Gray coded here when GRAY_CODE is set; no offset path exists
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stable_r <= '0;
        end else if (pop) begin // RULE_11 RULE_16
            stable_r <= GRAY_CODE ? ssps_pkg::to_gray(fifo_data) : fifo_data; // RULE_07 RULE_17
        end
    end

    // ****************************************
    // Link observation and monoflop (mclk domain)
    // ****************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_sync_r <= 2'h3;
            busy_sync_r <= 2'h0;
            sclk_d_r <= 1'b1;
        end else begin
            sclk_sync_r <= {sclk_sync_r[0], link.sclk};
            busy_sync_r <= {busy_sync_r[0], frame_r};
            sclk_d_r <= sclk_sync_r[1];
        end
    end

    assign sclk_s = sclk_sync_r[1];
    assign busy_s = busy_sync_r[1];
    assign busy_o = busy_s;

    // Restarts on every clock edge, runs while the clock rests high
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mono_r <= '0;
        end else if (!busy_s || (sclk_s != sclk_d_r)) begin
            mono_r <= '0;
        end else if (sclk_s && (mono_r != MW'(ssps_pkg::MONO_CYC))) begin
            mono_r <= mono_r + MW'(1); // RULE_06
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clr_r <= 1'b0;
        end else begin
            clr_r <= busy_s && sclk_s && sclk_d_r
                     && (mono_r == MW'(ssps_pkg::MONO_CYC - 1)); // RULE_06
        end
    end

    // Link clock stands still between frames, so mclk ends the frame
    assign frm_rst_n = nrst_i && !clr_r;

    // ****************************************
    // Frame shifter (link clock domain)
    // ****************************************
    always_ff @(negedge link.sclk or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            frame_r <= 1'b0;
            snap_r <= '0;
        end else if (!frame_r) begin
            frame_r <= 1'b1; // RULE_01
            snap_r <= {ssps_pkg::PAD_ZERO, stable_r}; // RULE_02 RULE_09 RULE_12
        end
    end

    always_ff @(posedge link.sclk or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            idx_r <= '0;
            out_r <= 1'b1; // RULE_06
        end else if (frame_r) begin
            if (idx_r < IW'(FB)) begin
                out_r <= snap_r[IW'(FB - 1) - idx_r]; // RULE_03 RULE_08 RULE_10
                idx_r <= idx_r + IW'(1);
            end else begin
                out_r <= 1'b0; // RULE_05
            end
        end
    end

    assign link.sdata = out_r;

endmodule : ssps_slave
`default_nettype wire

// [logic/ssps_master.sv]
// Purpose: SSI master end that clocks frames and collects positions
// Assumes: ssps_fifo compiled before this file
// Notes: Link clock derived from mclk_i by a divider
`timescale 1ns/100ps
`default_nettype none

module ssps_master #(
    parameter int HALF_DIV = ssps_pkg::HALF_DIV_MIN,
    parameter bit GRAY_CODE = ssps_pkg::GRAY_DEFAULT,
    parameter int DEPTH = ssps_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    output logic [ssps_pkg::POS_BITS-1:0] word_o,
    output logic pad_err_o,
    output logic word_valid_o,
    input wire logic word_ready_i,
    output logic busy_o,
    ssps_if.host link
);
    localparam int PB = ssps_pkg::POS_BITS;
    localparam int FB = ssps_pkg::FRAME_BITS;
    localparam int IW = ssps_pkg::IDX_W;
    localparam int CW = ssps_pkg::CNT_W;

    typedef enum logic [1:0] {
        M_IDLE = 2'h0,
        M_LOW = 2'h1,
        M_HIGH = 2'h3,
        M_PAUSE = 2'h2
    } ssps_mstate_t;

    ssps_mstate_t state_r;
    logic [CW-1:0] cnt_r;
    logic [IW-1:0] rise_r;
    logic sclk_r;
    logic [1:0] data_sync_r;
    logic [FB-1:0] sh_r;
    logic push_r;
    logic fifo_rdy;
    logic half_done;
    logic [PB:0] fifo_out;

    assign half_done = (cnt_r == CW'(HALF_DIV - 1)); // RULE_13 RULE_14

    // ****************************************
    // Frame sequencer
    // ****************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= M_IDLE;
            cnt_r <= '0;
            rise_r <= '0;
            sclk_r <= 1'b1;
        end else begin
            unique case (state_r)
                M_IDLE: begin
                    cnt_r <= '0;
                    rise_r <= '0;
                    if (start_i && fifo_rdy) begin
                        state_r <= M_LOW; // RULE_01
                        sclk_r <= 1'b0;
                    end
                end
                M_LOW: begin
                    cnt_r <= half_done ? '0 : cnt_r + CW'(1);
                    if (half_done) begin
                        state_r <= M_HIGH;
                        sclk_r <= 1'b1;
                        rise_r <= rise_r + IW'(1);
                    end
                end
                M_HIGH: begin
                    cnt_r <= half_done ? '0 : cnt_r + CW'(1);
                    if (half_done && (rise_r == IW'(FB + 1))) begin
                        state_r <= M_PAUSE; // RULE_04 RULE_18
                    end else if (half_done) begin
                        state_r <= M_LOW;
                        sclk_r <= 1'b0;
                    end
                end
                M_PAUSE: begin
                    cnt_r <= cnt_r + CW'(1);
                    if (cnt_r == CW'(ssps_pkg::PAUSE_CYC - 1)) begin
                        state_r <= M_IDLE; // RULE_15
                    end
                end
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign busy_o = (state_r != M_IDLE);

    // ****************************************
    // Data capture
    // ****************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            data_sync_r <= 2'h3;
        end else begin
            data_sync_r <= {data_sync_r[0], link.sdata};
        end
    end

    // Samples just before each falling edge after the first, mid-bit
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_r <= '0;
        end else if (state_r == M_HIGH && half_done && rise_r != IW'(FB + 1)) begin
            sh_r <= {sh_r[FB-2:0], data_sync_r[1]};
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            push_r <= 1'b0;
        end else begin
            push_r <= (state_r == M_HIGH) && half_done && (rise_r == IW'(FB + 1));
        end
    end

    ssps_fifo #(
        .WIDTH(PB + 1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_valid_i(push_r),
        .in_ready_o(fifo_rdy),
        .in_data_i({sh_r[FB-1:PB] != ssps_pkg::PAD_ZERO,
                    GRAY_CODE ? ssps_pkg::from_gray(sh_r[PB-1:0]) : sh_r[PB-1:0]}),
        .out_valid_o(word_valid_o),
        .out_ready_i(word_ready_i),
        .out_data_o(fifo_out)
    );

    assign word_o = fifo_out[PB-1:0];
    assign pad_err_o = fifo_out[PB];

endmodule : ssps_master
`default_nettype wire

// [verif/ssps_link_chk.sv]
// Purpose: Wire checks on the serial link between master and slave ends
// Assumes: sclk comes from an mclk_i flop, so sampling on mclk_i sees every edge
// Notes: Frame state is rebuilt here from sclk alone
`timescale 1ns/100ps
`default_nettype none
module ssps_link_chk (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic sclk,
    input wire logic sdata
);
    localparam int MONO = ssps_pkg::MONO_CYC;
    logic sclk_q;
    logic act_r;
    logic fell;
    logic rose;
    logic [5:0] rise_cnt;
    logic [9:0] gap_cnt;
    assign fell = sclk_q & ~sclk;
    assign rose = ~sclk_q & sclk;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ****************************************
    // Frame tracking
    // ****************************************
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) sclk_q <= 1'b1;
        else sclk_q <= sclk;
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) gap_cnt <= 10'h3ff;
        else if (fell || rose) gap_cnt <= 10'h000;
        else if (gap_cnt != 10'h3ff) gap_cnt <= gap_cnt + 10'h001;
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) act_r <= 1'b0;
        else if (fell && !act_r) act_r <= 1'b1;
        else if (act_r && sclk && gap_cnt == 10'(MONO)) act_r <= 1'b0;
    end
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) rise_cnt <= 6'h00;
        else if (fell && !act_r) rise_cnt <= 6'h00;
        else if (rose && rise_cnt != 6'h3f) rise_cnt <= rise_cnt + 6'h01;
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_pre_msb; act_r && !sclk && rise_cnt == 6'h00 |-> sdata; endproperty
    a_pre_msb: assert property (p_pre_msb)
        else $error("data moved before first rise");
    property p_hold; act_r && !rose |-> $stable(sdata); endproperty
    a_hold: assert property (p_hold)
        else $error("data changed off a rising edge");
    property p_pad; fell && act_r && rise_cnt inside {[6'h01:6'h05]} |-> !sdata; endproperty
    a_pad: assert property (p_pad)
        else $error("leading pad bit not zero");
    property p_surplus; act_r && sclk && rise_cnt > 6'h19 && gap_cnt < 10'(MONO) |-> !sdata;
    endproperty
    a_surplus: assert property (p_surplus)
        else $error("surplus clock not low or early rearm");
    property p_rearm; act_r && sclk && gap_cnt == 10'(MONO) |-> ##[1:8] sdata; endproperty
    a_rearm: assert property (p_rearm)
        else $error("data not high after hold time");
    property p_idle; !act_r && sclk && gap_cnt > 10'(MONO + 8) |-> sdata; endproperty
    a_idle: assert property (p_idle)
        else $error("idle data not high");
    property p_len; act_r && sclk && gap_cnt == 10'h078 |-> rise_cnt == 6'h1a; endproperty
    a_len: assert property (p_len)
        else $error("frame rising edge count wrong");
    property p_rate; (fell || rose) && act_r |-> gap_cnt inside {[10'h009:10'h063]}; endproperty
    a_rate: assert property (p_rate)
        else $error("clock phase out of range");
    property p_pause; fell && !act_r |-> gap_cnt >= 10'h140; endproperty
    a_pause: assert property (p_pause)
        else $error("inter frame pause too short");
    property p_park; !act_r && !sclk |-> sclk_q; endproperty
    a_park: assert property (p_park)
        else $error("clock low between frames");
    c_start: cover property (fell && !act_r);
    c_surplus: cover property (act_r && sclk && rise_cnt == 6'h1a);
    c_rearm: cover property (act_r && sclk && gap_cnt == 10'(MONO));
endmodule : ssps_link_chk
`default_nettype wire

// [verif/ssi_position_slave_tb.sv]
// Purpose: Self-checking bench for master and slave ends of the serial link
// Assumes: Second slave is clocked by the bench to break frame length on purpose
// Notes: Inputs change on the falling edge of mclk_i, except the second link clock, which frame_b drives on its own delays
`timescale 1ns/100ps
`default_nettype none
module ssi_position_slave_tb;
    logic mclk_i, nrst_i, val_a, val_b, rdy_a, rdy_b, busy_a, busy_b;
    logic start, pad_err, wvalid, wready, mbusy;
    logic [19:0] pos_a, pos_b, word;
    logic [24:0] w;
    logic [31:0] g;
    logic [19:0] tv [4] = '{20'h00000, 20'h00001, 20'h12345, 20'hfffff};
    int fails, n_compared, cyc, n, k;
    ssps_if i_ssps_if ();
    ssps_if i_ssps_if_b ();
    ssps_slave i_ssps_slave (.mclk_i(mclk_i), .nrst_i(nrst_i), .pos_i(pos_a), .pos_valid_i(val_a),
        .pos_ready_o(rdy_a), .busy_o(busy_a), .link(i_ssps_if));
    ssps_slave i_ssps_slave_b (.mclk_i(mclk_i), .nrst_i(nrst_i), .pos_i(pos_b), .pos_valid_i(val_b),
        .pos_ready_o(rdy_b), .busy_o(busy_b), .link(i_ssps_if_b));
    ssps_master i_ssps_master (.mclk_i(mclk_i), .nrst_i(nrst_i), .start_i(start), .word_o(word),
        .pad_err_o(pad_err), .word_valid_o(wvalid), .word_ready_i(wready), .busy_o(mbusy),
        .link(i_ssps_if));
    ssps_link_chk i_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk(i_ssps_if.sclk),
        .sdata(i_ssps_if.sdata));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [24:0] frm(input logic [19:0] p);
        return {5'h00, p ^ (p >> 1)};
    endfunction : frm
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    task automatic push(input bit s, input logic [19:0] p);
        int t;
        t = 0;
        @(negedge mclk_i);
        if (s) {pos_b, val_b} = {p, 1'b1};
        else {pos_a, val_a} = {p, 1'b1};
        while ((s ? rdy_b : rdy_a) !== 1'b1 && t < 50) begin
            @(negedge mclk_i);
            t++;
        end
        if (t >= 50) fails++;
        @(negedge mclk_i);
        {val_a, val_b} = 2'h0;
    endtask : push
    task automatic pop();
        @(negedge mclk_i);
        wready = 1'b1;
        @(negedge mclk_i);
        wready = 1'b0;
    endtask : pop
    task automatic wait_lvl(input int s, input logic lvl, output int t);
        t = 0;
        while (t < 2000 && (s == 0 ? wvalid : s == 1 ? mbusy : i_ssps_if_b.sdata) !== lvl) begin
            @(negedge mclk_i);
            t++;
        end
        if (t >= 2000) fails++;
    endtask : wait_lvl
    task automatic frame_b(input int nr, output logic [31:0] got);
        got = 32'h0;
        for (int j = 0; j < nr; j++) begin
            #24 i_ssps_if_b.sclk = 1'b1;
            #12 got = {got[30:0], i_ssps_if_b.sdata};
            #12;
            if (j < nr - 1) i_ssps_if_b.sclk = 1'b0;
        end
    endtask : frame_b
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge mclk_i);
            cyc++;
            if (cyc == 40000) begin
                fails++;
                close_out();
            end
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {nrst_i, val_a, val_b, start, wready, pos_a, pos_b} = '0;
        i_ssps_if_b.sclk = 1'b1;
        repeat (16) @(negedge mclk_i);
        nrst_i = 1'b1;
        chk(32'({i_ssps_if.sclk, i_ssps_if.sdata, wvalid, rdy_a, mbusy, busy_a}), 32'h34);
        $display("test reset done");
        foreach (tv[i]) begin
            push(1'b0, tv[i]);
            repeat (6) @(negedge mclk_i);
            fork
                repeat (26) begin
                    @(negedge i_ssps_if.sclk);
                    w = {w[23:0], i_ssps_if.sdata};
                end
                begin
                    @(negedge mclk_i);
                    start = 1'b1;
                    @(negedge mclk_i);
                    start = 1'b0;
                end
            join
            chk({7'h00, w}, {7'h00, frm(tv[i])});
            wait_lvl(0, 1'b1, n);
            chk(32'({pad_err, word}), 32'({1'b0, tv[i]}));
            pop();
            wait_lvl(1, 1'b0, n);
        end
        $display("test stream done");
        start = 1'b1;
        {k, n} = '0;
        while (k < 400 && n < 20000) begin
            @(negedge mclk_i);
            n++;
            k = (mbusy === 1'b1) ? 0 : k + 1;
        end
        start = 1'b0;
        if (n >= 20000) fails++;
        k = 0;
        while (wvalid === 1'b1 && k < 20) begin
            chk(32'({pad_err, word}), 32'({1'b0, tv[3]}));
            pop();
            k++;
        end
        chk(32'(k), 32'(ssps_pkg::FIFO_DEPTH));
        $display("test master fifo done");
        push(1'b1, 20'h2468a);
        repeat (6) @(negedge mclk_i);
        i_ssps_if_b.sclk = 1'b0;
        repeat (5) @(negedge mclk_i);
        chk(32'(busy_b), 32'h1);
        for (int j = 0; j < 8; j++) push(1'b1, 20'h00010 + 20'(j));
        chk(32'(rdy_b), 32'h0);
        {pos_b, val_b} = {20'h77777, 1'b1};
        repeat (3) @(negedge mclk_i);
        chk(32'(rdy_b), 32'h0);
        val_b = 1'b0;
        frame_b(30, g);
        chk(g, {2'h0, frm(20'h2468a), 5'h00});
        wait_lvl(2, 1'b1, n);
        chk(32'(n >= 239 && n <= 250), 32'h1);
        repeat (340) @(negedge mclk_i);
        chk(32'({busy_b, rdy_b}), 32'h1);
        i_ssps_if_b.sclk = 1'b0;
        frame_b(25, g);
        chk(g, {7'h00, frm(20'h00017)});
        $display("test slave fifo done");
        close_out();
    end
endmodule : ssi_position_slave_tb
`default_nettype wire
